// file: include/abx_pkg.sv
// abx_pkg: shared constants, opcode enumeration and state layout of the
// 8-bit execute unit.
// assumes the fetch/decode stage hands over one decoded operation at a time.
package abx_pkg;

  // program counter, word immediate and offset widths
  localparam int PC_W = 16;
  localparam int WORD_K_W = 6;
  localparam int OFFSET_W = 12;

  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // status_register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // which flags each class of operation is allowed to touch
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_ZCNVH = 8'h2F;
  localparam logic [7:0] MASK_ZCNVS = 8'h1F;
  localparam logic [7:0] MASK_ZCNV = 8'h0F;
  localparam logic [7:0] MASK_ZNV = 8'h0E;

  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_WORD = 2'h2;
  localparam logic [1:0] CYC_PTR_JUMP = 2'h2;
  localparam logic [1:0] CYC_PTR_CALL = 2'h3;
  localparam logic [1:0] CYC_REL_JUMP = 2'h2;
  localparam logic [1:0] CYC_REL_CALL = 2'h3;
  localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
  localparam logic [1:0] CYC_BR_TAKEN = 2'h2;

  // program counter steps of a skip over a one- or two-word instruction
  localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO = 16'h0003;

  typedef enum logic [5:0] {
    OP_NOP,
    OP_ADD,
    OP_ADD_CARRY,
    OP_WORD_PLUS_IMM,
    OP_SUB,
    OP_MINUS_IMM,
    OP_DIFF_BORROW,
    OP_IMM_BORROW,
    OP_WORD_MINUS_IMM,
    OP_AND,
    OP_MASK_IMM,
    OP_OR,
    OP_MERGE_IMM,
    OP_XOR,
    OP_INVERT,
    OP_TWOS_COMPLEMENT,
    OP_SET_MASK_BITS,
    OP_CLEAR_MASK_BITS,
    OP_INC,
    OP_DEC,
    OP_ZERO_SIGN_TEST,
    OP_CLEAR,
    OP_SET_ALL,
    OP_REL_JUMP,
    OP_POINTER_JUMP,
    OP_REL_CALL,
    OP_POINTER_INVOKE,
    OP_SKIP_IF_EQUAL,
    OP_COMPARE,
    OP_COMPARE_CARRY,
    OP_COMPARE_IMM,
    OP_SKIP_REG_BIT_LOW,
    OP_SKIP_REG_BIT_HIGH,
    OP_SKIP_IO_BIT_LOW,
    OP_SKIP_IO_BIT_HIGH,
    OP_BRANCH_FLAG_HIGH,
    OP_BRANCH_FLAG_LOW,
    OP_BRANCH_EQUAL,
    OP_BRANCH_UNEQUAL,
    OP_BRANCH_CARRY_HIGH,
    OP_BRANCH_CARRY_LOW
  } abx_op_t;

  typedef struct packed {
    logic active;
    logic [1:0] cnt;
    logic [15:0] pc;
    logic [7:0] status;
    logic [15:0] pend_pc;
    logic [7:0] pend_status;
    logic pend_wr_byte;
    logic pend_wr_word;
    logic pend_push;
    logic done;
    logic wr_byte;
    logic wr_word;
    logic push;
    logic [7:0] byte_res;
    logic [15:0] word_res;
    logic [15:0] ret_addr;
  } abx_state_t;

endpackage

// file: verilog/abx_alu8.sv
// abx_alu8: 8-bit adder/subtracter with carry-in and flag outputs.
// assumes the caller picks operands and decides which flags are kept.
`timescale 1ns/10ps
module abx_alu8 (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic sub,
  // result and flags
  output logic [7:0] res,
  output logic carry,
  output logic half,
  output logic ovf
);

  logic [8:0] full;
  logic [4:0] nib;

  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end
  end

  assign res = full[7:0];
  // bit 8 is carry on add and borrow on subtract
  assign carry = full[8];
  assign half = nib[4];
  assign ovf = sub ? ((a[7] != b[7]) && (full[7] != a[7]))
                   : ((a[7] == b[7]) && (full[7] != a[7]));

endmodule

// file: verilog/abx_exec.sv
// abx_exec: execute stage for arithmetic, logic, compare, skip, jump and
// branch operations of an 8-bit core; owns the program counter and status.
// assumes decode supplies operand values and 12-bit signed offsets (widened here), and
// that the register file writes back on wr_byte / wr_word strobes.
`timescale 1ns/10ps
module abx_exec (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // operation request
  input wire logic start,
  input wire abx_pkg::abx_op_t op,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  input wire logic [15:0] pair_val,
  input wire logic [7:0] io_val,
  input wire logic [2:0] bit_sel,
  input wire logic [11:0] offset,
  input wire logic next_two_word,
  output logic ready,
  // write back and completion
  output logic done,
  output logic wr_byte,
  output logic [7:0] byte_res,
  output logic wr_word,
  output logic [15:0] word_res,
  // call return address
  output logic push,
  output logic [15:0] ret_addr,
  // architectural state
  output logic [15:0] pc,
  output logic [7:0] status
);

  abx_pkg::abx_state_t st_reg;
  abx_pkg::abx_state_t st_next;

  // alu operand selection
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic alu_sub;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_h;
  logic alu_v;

  // word datapath
  logic [16:0] wsum;
  logic [15:0] kword;
  logic w_minus;
  logic w_v;

  // decode results
  logic [1:0] d_cyc;
  logic d_wr_byte;
  logic [7:0] d_byte;
  logic d_wr_word;
  logic [7:0] d_mask;
  logic [7:0] d_flags;
  logic [15:0] d_pc;
  logic d_push;
  logic [7:0] lres;
  logic skip;
  logic br;
  logic take;

  logic [15:0] pc_seq;
  logic [15:0] pc_rel;
  logic [15:0] pc_skip;

  // place result-driven flags into a copy of status; the mask picks which survive
  function automatic logic [7:0] put_flags(input logic [7:0] base, input logic [7:0] res,
                                           input logic c, input logic v, input logic h);
    logic [7:0] f;
    f = base;
    f[abx_pkg::FLAG_Z] = (res == 8'h00);
    f[abx_pkg::FLAG_N] = res[7];
    f[abx_pkg::FLAG_C] = c;
    f[abx_pkg::FLAG_V] = v;
    f[abx_pkg::FLAG_H] = h;
    return f;
  endfunction

  abx_alu8 u_alu (
    .a(alu_a),
    .b(alu_b),
    .cin(alu_cin),
    .sub(alu_sub),
    .res(alu_res),
    .carry(alu_c),
    .half(alu_h),
    .ovf(alu_v)
  );

  always_comb begin
    alu_a = dst_val;
    alu_b = src_val;
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    case (op)
      abx_pkg::OP_ADD_CARRY: begin
        alu_cin = st_reg.status[abx_pkg::FLAG_C];
      end
      abx_pkg::OP_SUB, abx_pkg::OP_MINUS_IMM, abx_pkg::OP_COMPARE,
      abx_pkg::OP_COMPARE_IMM: begin
        alu_sub = 1'b1;
      end
      abx_pkg::OP_DIFF_BORROW, abx_pkg::OP_IMM_BORROW, abx_pkg::OP_COMPARE_CARRY: begin
        alu_sub = 1'b1;
        alu_cin = st_reg.status[abx_pkg::FLAG_C];
      end
      abx_pkg::OP_TWOS_COMPLEMENT: begin
        alu_a = 8'h00;
        alu_b = dst_val;
        alu_sub = 1'b1;
      end
      abx_pkg::OP_INC: begin
        alu_b = 8'h01;
      end
      abx_pkg::OP_DEC: begin
        alu_b = 8'h01;
        alu_sub = 1'b1;
      end
      default: begin
        alu_sub = 1'b0;
      end
    endcase
  end

  // word ops: six-bit immediate against the register pair
  assign kword = {10'h000, src_val[abx_pkg::WORD_K_W-1:0]};
  assign w_minus = (op == abx_pkg::OP_WORD_MINUS_IMM);
  assign wsum = w_minus ? ({1'b0, pair_val} - {1'b0, kword})
                        : ({1'b0, pair_val} + {1'b0, kword});
  assign w_v = w_minus ? (pair_val[15] & ~wsum[15]) : (~pair_val[15] & wsum[15]);

  assign pc_seq = st_reg.pc + 16'h0001;
  assign pc_rel = st_reg.pc + {{4{offset[11]}}, offset} + 16'h0001;
  assign pc_skip = st_reg.pc + (next_two_word ? abx_pkg::PC_SKIP_TWO : abx_pkg::PC_SKIP_ONE);

  // skip and branch conditions
  always_comb begin
    case (op)
      abx_pkg::OP_SKIP_IF_EQUAL: skip = (dst_val == src_val);
      abx_pkg::OP_SKIP_REG_BIT_LOW: skip = ~src_val[bit_sel];
      abx_pkg::OP_SKIP_REG_BIT_HIGH: skip = src_val[bit_sel];
      abx_pkg::OP_SKIP_IO_BIT_LOW: skip = ~io_val[bit_sel];
      abx_pkg::OP_SKIP_IO_BIT_HIGH: skip = io_val[bit_sel];
      default: skip = 1'b0;
    endcase
    case (op)
      abx_pkg::OP_BRANCH_FLAG_HIGH: br = st_reg.status[bit_sel];
      abx_pkg::OP_BRANCH_FLAG_LOW: br = ~st_reg.status[bit_sel];
      abx_pkg::OP_BRANCH_EQUAL: br = st_reg.status[abx_pkg::FLAG_Z];
      abx_pkg::OP_BRANCH_UNEQUAL: br = ~st_reg.status[abx_pkg::FLAG_Z];
      abx_pkg::OP_BRANCH_CARRY_HIGH: br = st_reg.status[abx_pkg::FLAG_C];
      abx_pkg::OP_BRANCH_CARRY_LOW: br = ~st_reg.status[abx_pkg::FLAG_C];
      default: br = 1'b0;
    endcase
  end

  // operation decode: result, flags, next pc and cycle count
  always_comb begin
    d_cyc = abx_pkg::CYC_ONE;
    d_wr_byte = 1'b0;
    d_byte = alu_res;
    d_wr_word = 1'b0;
    d_mask = abx_pkg::MASK_NONE;
    d_flags = st_reg.status;
    d_pc = pc_seq;
    d_push = 1'b0;
    lres = 8'h00;
    case (op)
      abx_pkg::OP_ADD, abx_pkg::OP_ADD_CARRY, abx_pkg::OP_SUB, abx_pkg::OP_MINUS_IMM,
      abx_pkg::OP_DIFF_BORROW, abx_pkg::OP_IMM_BORROW, abx_pkg::OP_TWOS_COMPLEMENT: begin
        d_wr_byte = 1'b1;
        d_mask = abx_pkg::MASK_ZCNVH;
        d_flags = put_flags(st_reg.status, alu_res, alu_c, alu_v, alu_h);
      end
      abx_pkg::OP_COMPARE, abx_pkg::OP_COMPARE_CARRY, abx_pkg::OP_COMPARE_IMM: begin
        d_mask = abx_pkg::MASK_ZCNVH;
        d_flags = put_flags(st_reg.status, alu_res, alu_c, alu_v, alu_h);
      end
      abx_pkg::OP_INC, abx_pkg::OP_DEC: begin
        d_wr_byte = 1'b1;
        d_mask = abx_pkg::MASK_ZNV;
        d_flags = put_flags(st_reg.status, alu_res, 1'b0, alu_v, 1'b0);
      end
      abx_pkg::OP_AND, abx_pkg::OP_MASK_IMM, abx_pkg::OP_OR, abx_pkg::OP_MERGE_IMM,
      abx_pkg::OP_XOR, abx_pkg::OP_SET_MASK_BITS, abx_pkg::OP_CLEAR_MASK_BITS,
      abx_pkg::OP_ZERO_SIGN_TEST, abx_pkg::OP_CLEAR: begin
        case (op)
          abx_pkg::OP_AND, abx_pkg::OP_MASK_IMM: lres = dst_val & src_val;
          abx_pkg::OP_XOR: lres = dst_val ^ src_val;
          abx_pkg::OP_CLEAR_MASK_BITS: lres = dst_val & (8'hFF - src_val);
          abx_pkg::OP_ZERO_SIGN_TEST: lres = dst_val & dst_val;
          abx_pkg::OP_CLEAR: lres = 8'h00;
          default: lres = dst_val | src_val;
        endcase
        d_byte = lres;
        // the test form leaves the register alone; only flags change
        d_wr_byte = (op != abx_pkg::OP_ZERO_SIGN_TEST);
        d_mask = abx_pkg::MASK_ZNV;
        d_flags = put_flags(st_reg.status, lres, 1'b0, 1'b0, 1'b0);
      end
      abx_pkg::OP_INVERT: begin
        d_byte = 8'hFF - dst_val;
        d_wr_byte = 1'b1;
        d_mask = abx_pkg::MASK_ZCNV;
        d_flags = put_flags(st_reg.status, 8'hFF - dst_val, 1'b1, 1'b0, 1'b0);
      end
      abx_pkg::OP_SET_ALL: begin
        d_byte = 8'hFF;
        d_wr_byte = 1'b1;
      end
      abx_pkg::OP_WORD_PLUS_IMM, abx_pkg::OP_WORD_MINUS_IMM: begin
        d_cyc = abx_pkg::CYC_WORD;
        d_wr_word = 1'b1;
        d_mask = abx_pkg::MASK_ZCNVS;
        d_flags = st_reg.status;
        d_flags[abx_pkg::FLAG_Z] = (wsum[15:0] == 16'h0000);
        d_flags[abx_pkg::FLAG_N] = wsum[15];
        d_flags[abx_pkg::FLAG_C] = wsum[16];
        d_flags[abx_pkg::FLAG_V] = w_v;
        d_flags[abx_pkg::FLAG_S] = wsum[15] ^ w_v;
      end
      abx_pkg::OP_REL_JUMP: begin
        d_cyc = abx_pkg::CYC_REL_JUMP;
        d_pc = pc_rel;
      end
      abx_pkg::OP_REL_CALL: begin
        d_cyc = abx_pkg::CYC_REL_CALL;
        d_pc = pc_rel;
        d_push = 1'b1;
      end
      abx_pkg::OP_POINTER_JUMP: begin
        d_cyc = abx_pkg::CYC_PTR_JUMP;
        d_pc = pair_val;
      end
      abx_pkg::OP_POINTER_INVOKE: begin
        d_cyc = abx_pkg::CYC_PTR_CALL;
        d_pc = pair_val;
        d_push = 1'b1;
      end
      abx_pkg::OP_SKIP_IF_EQUAL, abx_pkg::OP_SKIP_REG_BIT_LOW,
      abx_pkg::OP_SKIP_REG_BIT_HIGH, abx_pkg::OP_SKIP_IO_BIT_LOW,
      abx_pkg::OP_SKIP_IO_BIT_HIGH: begin
        if (skip) begin
          d_pc = pc_skip;
          d_cyc = next_two_word ? abx_pkg::CYC_SKIP_TWO : abx_pkg::CYC_SKIP_ONE;
        end
      end
      abx_pkg::OP_BRANCH_FLAG_HIGH, abx_pkg::OP_BRANCH_FLAG_LOW,
      abx_pkg::OP_BRANCH_EQUAL, abx_pkg::OP_BRANCH_UNEQUAL,
      abx_pkg::OP_BRANCH_CARRY_HIGH, abx_pkg::OP_BRANCH_CARRY_LOW: begin
        if (br) begin
          d_pc = pc_rel;
          d_cyc = abx_pkg::CYC_BR_TAKEN;
        end
      end
      default: begin
        d_cyc = abx_pkg::CYC_ONE;
      end
    endcase
  end

  // one request at a time; multi-cycle ops hold off the next one
  assign take = start && !st_reg.active;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.wr_byte = 1'b0;
    st_next.wr_word = 1'b0;
    st_next.push = 1'b0;
    if (take) begin
      st_next.byte_res = d_byte;
      st_next.word_res = wsum[15:0];
      st_next.ret_addr = pc_seq;
      if (d_cyc == abx_pkg::CYC_ONE) begin
        st_next.pc = d_pc;
        st_next.status = (st_reg.status & ~d_mask) | (d_flags & d_mask);
        st_next.done = 1'b1;
        st_next.wr_byte = d_wr_byte;
        st_next.wr_word = d_wr_word;
        st_next.push = d_push;
      end else begin
        // results wait until the last cycle so pc and status move together
        st_next.active = 1'b1;
        st_next.cnt = d_cyc - 2'h1;
        st_next.pend_pc = d_pc;
        st_next.pend_status = (st_reg.status & ~d_mask) | (d_flags & d_mask);
        st_next.pend_wr_byte = d_wr_byte;
        st_next.pend_wr_word = d_wr_word;
        st_next.pend_push = d_push;
      end
    end else if (st_reg.active) begin
      if (st_reg.cnt == 2'h1) begin
        st_next.active = 1'b0;
        st_next.cnt = 2'h0;
        st_next.pc = st_reg.pend_pc;
        st_next.status = st_reg.pend_status;
        st_next.done = 1'b1;
        st_next.wr_byte = st_reg.pend_wr_byte;
        st_next.wr_word = st_reg.pend_wr_word;
        st_next.push = st_reg.pend_push;
      end else begin
        st_next.cnt = st_reg.cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.pc <= abx_pkg::PC_RESET;
      st_reg.status <= abx_pkg::STATUS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ready = !st_reg.active;
  assign done = st_reg.done;
  assign wr_byte = st_reg.wr_byte;
  assign byte_res = st_reg.byte_res;
  assign wr_word = st_reg.wr_word;
  assign word_res = st_reg.word_res;
  assign push = st_reg.push;
  assign ret_addr = st_reg.ret_addr;
  assign pc = st_reg.pc;
  assign status = st_reg.status;

endmodule

// file: test/abx_exec_chk.sv
// abx_exec_chk: concurrent checks on the execute stage ports.
// assumes it is bound to abx_exec and sees its ports only.
`timescale 1ns/10ps
module abx_exec_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // request
  input wire logic start,
  input wire abx_pkg::abx_op_t op,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  input wire logic [15:0] pair_val,
  input wire logic [7:0] io_val,
  input wire logic [2:0] bit_sel,
  input wire logic [11:0] offset,
  input wire logic next_two_word,
  input wire logic ready,
  // results
  input wire logic done,
  input wire logic wr_byte,
  input wire logic [7:0] byte_res,
  input wire logic wr_word,
  input wire logic [15:0] word_res,
  input wire logic push,
  input wire logic [15:0] ret_addr,
  input wire logic [15:0] pc,
  input wire logic [7:0] status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence take_s(abx_pkg::abx_op_t o);
    start && ready && op == o;
  endsequence
  // busy cycle: nothing committed yet
  sequence hold_s;
    !ready && !done;
  endsequence

  adc_result_a: assert property (take_s(abx_pkg::OP_ADD_CARRY) |=> done && wr_byte &&
    byte_res == $past(dst_val) + $past(src_val) + 8'($past(status[abx_pkg::FLAG_C])))
    else $error("add with carry wrong");
  word_plus_a: assert property (take_s(abx_pkg::OP_WORD_PLUS_IMM) |=> hold_s ##1
    done && wr_word && word_res == $past(pair_val, 2) + 16'($past(src_val[5:0], 2)))
    else $error("word plus wrong");
  invert_value_a: assert property (take_s(abx_pkg::OP_INVERT) |=>
    byte_res == ~$past(dst_val) && status[abx_pkg::FLAG_C] && !status[abx_pkg::FLAG_V])
    else $error("invert wrong");
  logic_carry_a: assert property (start && ready && op inside {abx_pkg::OP_AND,
    abx_pkg::OP_OR, abx_pkg::OP_XOR, abx_pkg::OP_MASK_IMM, abx_pkg::OP_MERGE_IMM} |=> done
    && status[abx_pkg::FLAG_C] == $past(status[abx_pkg::FLAG_C]) && !status[abx_pkg::FLAG_V])
    else $error("logic op touched carry");
  ptr_call_a: assert property (take_s(abx_pkg::OP_POINTER_INVOKE) |=> hold_s[*2] ##1
    done && push && pc == $past(pair_val, 3) && status == $past(status, 3))
    else $error("pointer invoke wrong");
  skip_equal_a: assert property (take_s(abx_pkg::OP_SKIP_IF_EQUAL) ##0
    (dst_val == src_val && !next_two_word) |=> hold_s ##1 done && pc == $past(pc, 2) + 16'h0002)
    else $error("skip if equal wrong");
  branch_taken_a: assert property (take_s(abx_pkg::OP_BRANCH_EQUAL) ##0
    status[abx_pkg::FLAG_Z] |=> hold_s ##1 done &&
    pc == $past(pc, 2) + 16'($signed($past(offset, 2))) + 16'h0001)
    else $error("taken branch wrong");
  cmp_nowrite_a: assert property (take_s(abx_pkg::OP_COMPARE_IMM) |=>
    done && !wr_byte && status[abx_pkg::FLAG_C] == ($past(dst_val) < $past(src_val)))
    else $error("compare immediate wrong");
endmodule

bind abx_exec abx_exec_chk chk (.ref_clk(ref_clk), .reset(reset), .start(start), .op(op),
  .dst_val(dst_val), .src_val(src_val), .pair_val(pair_val), .io_val(io_val),
  .bit_sel(bit_sel), .offset(offset), .next_two_word(next_two_word), .ready(ready),
  .done(done), .wr_byte(wr_byte), .byte_res(byte_res), .wr_word(wr_word),
  .word_res(word_res), .push(push), .ret_addr(ret_addr), .pc(pc), .status(status));

// file: test/tb_alu_and_branch_execute.sv
// tb_alu_and_branch_execute: directed self-checking bench for abx_exec.
// assumes abx_exec_chk is bound in from its own file.
`timescale 1ns/10ps
module tb_alu_and_branch_execute;
  logic ref_clk, reset, start, next_two_word;
  abx_pkg::abx_op_t op;
  logic [7:0] dst_val, src_val, io_val, byte_res, status;
  logic [15:0] pair_val, word_res, ret_addr, pc, exp_pc;
  logic [2:0] bit_sel;
  logic [11:0] offset;
  logic ready, done, wr_byte, wr_word, push;
  int errors, compares;

  abx_exec dut (.ref_clk(ref_clk), .reset(reset), .start(start), .op(op),
    .dst_val(dst_val), .src_val(src_val), .pair_val(pair_val), .io_val(io_val),
    .bit_sel(bit_sel), .offset(offset), .next_two_word(next_two_word), .ready(ready),
    .done(done), .wr_byte(wr_byte), .byte_res(byte_res), .wr_word(wr_word),
    .word_res(word_res), .push(push), .ret_addr(ret_addr), .pc(pc), .status(status));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one request, then count cycles up to the done pulse
  task automatic run(input abx_pkg::abx_op_t o, input logic [7:0] d, input logic [7:0] s,
      input logic [15:0] p, input logic [2:0] b, input logic [11:0] k, input logic ntw,
      input int cyc, input logic [15:0] npc);
    int n;
    @(posedge ref_clk);
    start <= 1'b1;
    op <= o;
    dst_val <= d;
    src_val <= s;
    io_val <= d;
    pair_val <= p;
    bit_sel <= b;
    offset <= k;
    next_two_word <= ntw;
    @(posedge ref_clk);
    start <= 1'b0;
    n = 1;
    #1;
    while (done !== 1'b1) begin
      if (n >= 6) begin
        errors++;
        $display("[ERR] %0t no completion", $time);
        give_verdict();
      end
      @(posedge ref_clk);
      n++;
      #1;
    end
    check(16'(n), 16'(cyc));
    check(pc, npc);
    exp_pc = npc;
  endtask

  // wr 1'bx: write strobe not judged
  task automatic alu(input abx_pkg::abx_op_t o, input logic [7:0] d, input logic [7:0] s,
      input logic [7:0] res, input logic [7:0] st, input logic wr);
    run(o, d, s, 16'h0000, 3'h0, 12'h000, 1'b0, 1, exp_pc + 16'h0001);
    check(16'(status), 16'(st));
    if (wr !== 1'bx) check(16'(wr_byte), 16'(wr));
    if (wr !== 1'b0) check(16'(byte_res), 16'(res));
  endtask

  task automatic word(input abx_pkg::abx_op_t o, input logic [15:0] p, input logic [7:0] k,
      input logic [15:0] res, input logic [7:0] st);
    run(o, 8'h00, k, p, 3'h0, 12'h000, 1'b0, 2, exp_pc + 16'h0001);
    check(word_res, res);
    check(16'(wr_word), 16'h0001);
    check(16'(status), 16'(st));
  endtask

  task automatic flow(input abx_pkg::abx_op_t o, input logic [7:0] d, input logic [7:0] s,
      input logic [2:0] b, input logic [11:0] k, input logic ntw, input int cyc,
      input logic [15:0] step);
    logic [7:0] st0;
    st0 = status;
    run(o, d, s, 16'h0000, b, k, ntw, cyc, exp_pc + step);
    check(16'(status), 16'(st0));
  endtask

  task automatic sc_arith;
    alu(abx_pkg::OP_MINUS_IMM, 8'h00, 8'h01, 8'hFF, 8'h25, 1'b1);
    alu(abx_pkg::OP_DIFF_BORROW, 8'h05, 8'h02, 8'h02, 8'h00, 1'b1);
    alu(abx_pkg::OP_ADD_CARRY, 8'hFF, 8'h01, 8'h00, 8'h23, 1'b1);
    alu(abx_pkg::OP_IMM_BORROW, 8'h80, 8'h01, 8'h7E, 8'h28, 1'b1);
    alu(abx_pkg::OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 8'hFF, 8'h25, 1'b1);
    alu(abx_pkg::OP_ADD_CARRY, 8'h10, 8'h0F, 8'h20, 8'h20, 1'b1);
  endtask

  task automatic sc_logic;
    alu(abx_pkg::OP_INVERT, 8'h0F, 8'h00, 8'hF0, 8'h25, 1'b1);
    alu(abx_pkg::OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h23, 1'b1);
    alu(abx_pkg::OP_MERGE_IMM, 8'h80, 8'h01, 8'h81, 8'h25, 1'b1);
    alu(abx_pkg::OP_XOR, 8'h5A, 8'hFF, 8'hA5, 8'h25, 1'b1);
    alu(abx_pkg::OP_MASK_IMM, 8'h3C, 8'h0F, 8'h0C, 8'h21, 1'b1);
    alu(abx_pkg::OP_OR, 8'h00, 8'h00, 8'h00, 8'h23, 1'b1);
    alu(abx_pkg::OP_SET_MASK_BITS, 8'h01, 8'h80, 8'h81, 8'h25, 1'b1);
    alu(abx_pkg::OP_CLEAR_MASK_BITS, 8'hFF, 8'h0F, 8'hF0, 8'h25, 1'b1);
    alu(abx_pkg::OP_ZERO_SIGN_TEST, 8'h00, 8'h00, 8'h00, 8'h23, 1'bx);
    alu(abx_pkg::OP_COMPARE_IMM, 8'h10, 8'h20, 8'h00, 8'h05, 1'b0);
  endtask

  task automatic sc_word;
    word(abx_pkg::OP_WORD_PLUS_IMM, 16'h00FF, 8'h01, 16'h0100, 8'h00);
    word(abx_pkg::OP_WORD_PLUS_IMM, 16'hFFFF, 8'h01, 16'h0000, 8'h03);
    word(abx_pkg::OP_WORD_MINUS_IMM, 16'h0000, 8'h01, 16'hFFFF, 8'h15);
    word(abx_pkg::OP_WORD_MINUS_IMM, 16'h8000, 8'h3F, 16'h7FC1, 8'h18);
  endtask

  task automatic sc_skip;
    flow(abx_pkg::OP_SKIP_IF_EQUAL, 8'h33, 8'h33, 3'h0, 12'h000, 1'b0, 2, 16'h0002);
    flow(abx_pkg::OP_SKIP_IF_EQUAL, 8'h33, 8'h33, 3'h0, 12'h000, 1'b1, 3, 16'h0003);
    flow(abx_pkg::OP_SKIP_IF_EQUAL, 8'h33, 8'h34, 3'h0, 12'h000, 1'b0, 1, 16'h0001);
    // source and destination values differ, io follows destination, so a skip reading the wrong operand shows
    flow(abx_pkg::OP_SKIP_REG_BIT_LOW, 8'h00, 8'h04, 3'h2, 12'h000, 1'b0, 1,
      16'h0001);
    flow(abx_pkg::OP_SKIP_REG_BIT_HIGH, 8'h00, 8'h04, 3'h2, 12'h000, 1'b0, 2,
      16'h0002);
    flow(abx_pkg::OP_SKIP_IO_BIT_HIGH, 8'h80, 8'h00, 3'h7, 12'h000, 1'b1, 3,
      16'h0003);
    flow(abx_pkg::OP_SKIP_IO_BIT_LOW, 8'h80, 8'h01, 3'h0, 12'h000, 1'b0, 2, 16'h0002);
    run(abx_pkg::OP_POINTER_JUMP, 8'h00, 8'h00, 16'h1234, 3'h0, 12'h000, 1'b0, 2,
      16'h1234);
    check(16'(status), 16'h0018);
    run(abx_pkg::OP_POINTER_INVOKE, 8'h00, 8'h00, 16'h0200, 3'h0, 12'h000, 1'b0, 3,
      16'h0200);
    check(ret_addr, 16'h1235);
    check(16'(push), 16'h0001);
  endtask

  // status on entry: S and V set, C and Z clear
  task automatic sc_branch;
    flow(abx_pkg::OP_BRANCH_FLAG_HIGH, 8'h00, 8'h00, 3'h4, 12'h010, 1'b0, 2,
      16'h0011);
    flow(abx_pkg::OP_BRANCH_FLAG_LOW, 8'h00, 8'h00, 3'h4, 12'h010, 1'b0, 1, 16'h0001);
    flow(abx_pkg::OP_BRANCH_FLAG_LOW, 8'h00, 8'h00, 3'h0, 12'hFFE, 1'b0, 2, 16'hFFFF);
    flow(abx_pkg::OP_BRANCH_CARRY_HIGH, 8'h00, 8'h00, 3'h0, 12'h005, 1'b0, 1,
      16'h0001);
    flow(abx_pkg::OP_BRANCH_CARRY_LOW, 8'h00, 8'h00, 3'h0, 12'h005, 1'b0, 2,
      16'h0006);
    flow(abx_pkg::OP_BRANCH_EQUAL, 8'h00, 8'h00, 3'h0, 12'h005, 1'b0, 1, 16'h0001);
    flow(abx_pkg::OP_BRANCH_UNEQUAL, 8'h00, 8'h00, 3'h0, 12'h003, 1'b0, 2, 16'h0004);
    alu(abx_pkg::OP_ZERO_SIGN_TEST, 8'h00, 8'h00, 8'h00, 8'h12, 1'bx);
    flow(abx_pkg::OP_BRANCH_EQUAL, 8'h00, 8'h00, 3'h0, 12'hF80, 1'b0, 2, 16'hFF81);
    flow(abx_pkg::OP_BRANCH_UNEQUAL, 8'h00, 8'h00, 3'h0, 12'h003, 1'b0, 1, 16'h0001);
  endtask

  // status on entry: S and Z set; covers relative jump and call, nop, set-all and two compares
  task automatic sc_other;
    flow(abx_pkg::OP_REL_JUMP, 8'h00, 8'h00, 3'h0, 12'h00F, 1'b0, 2, 16'h0010);
    flow(abx_pkg::OP_REL_CALL, 8'h00, 8'h00, 3'h0, 12'h001, 1'b0, 3, 16'h0002);
    flow(abx_pkg::OP_NOP, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0, 1, 16'h0001);
    alu(abx_pkg::OP_SET_ALL, 8'h00, 8'h00, 8'hFF, 8'h12, 1'b1);
    alu(abx_pkg::OP_COMPARE, 8'h20, 8'h21, 8'h00, 8'h35, 1'b0);
    alu(abx_pkg::OP_COMPARE_CARRY, 8'h21, 8'h20, 8'h00, 8'h12, 1'b0);
  endtask

  initial begin
    errors = 0;
    compares = 0;
    exp_pc = 16'h0000;
    reset = 1'b1;
    start = 1'b0;
    op = abx_pkg::OP_NOP;
    dst_val = 8'h00;
    src_val = 8'h00;
    io_val = 8'h00;
    pair_val = 16'h0000;
    bit_sel = 3'h0;
    offset = 12'h000;
    next_two_word = 1'b0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    check(pc, 16'h0000);
    check(16'(status), 16'h0000);
    sc_arith();
    sc_logic();
    sc_word();
    sc_skip();
    sc_branch();
    sc_other();
    give_verdict();
  end
endmodule
